// File: logic/hsg_host.sv
// Peripheral-side controller for the two handshake groups of the device.
// Assumes the device pins arrive asynchronously and software uses APB.
//
// How it works
// - start refused when access width exceeds the assigned FIFO width.
// - access width is set before any data word is accepted.
// - configuration changes only while the run control field is reset.
// - request rises when we can take data or have valid data driven.
// - burst clock is driven by us or received from the device.
// - counted mode needs the counted bit and a count before run.
// - count-done flag rises after the last counted transfer.
// - residue flag shows data left after an input run stops.
// - writing all ones to the clear field clears the done and error flags.
// - data for the device is loaded before the run starts.
// - protocol setting selects the handshake parameter set.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
module hsg_host #(
  parameter int DATA_W = hsg_pkg::DATA_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [1:0]        group_req_out,
  input  wire logic [1:0]        group_ack_in,
  input  wire logic [1:0]        group_periph_clock_in,
  output logic      [1:0]        group_periph_clock_out,
  output logic      [1:0]        group_periph_clock_oe,
  input  wire logic [DATA_W-1:0] group1_data_in,
  input  wire logic [DATA_W-1:0] group2_data_in,
  output logic      [DATA_W-1:0] group1_data_out,
  output logic      [DATA_W-1:0] group2_data_out,
  output logic      [1:0]        group_data_oe
);

  logic [31:0]       ctrl_q    [2];
  logic [31:0]       count_q   [2];
  logic [31:0]       status_w  [2];
  logic [DATA_W-1:0] tx_q      [2];
  logic [DATA_W-1:0] rx_q      [2];
  logic [DATA_W-1:0] din_s2    [2];
  logic [DATA_W-1:0] dout_q    [2];
  logic [1:0]        tx_full_q;
  logic [1:0]        rx_valid_q;
  logic [1:0]        done_q;
  logic [1:0]        err_q;
  logic [31:0]       prdata_q;
  logic              wr_acc;
  logic              rd_acc;
  logic              addr_ok;
  logic              grp_sel;
  logic [4:0]        ofs;

  assign grp_sel = paddr[5];
  assign ofs     = paddr[4:0];
  assign addr_ok = (paddr[7:6] == 2'b00) &&
                   ((ofs == hsg_pkg::OFS_CTRL)   || (ofs == hsg_pkg::OFS_COUNT) ||
                    (ofs == hsg_pkg::OFS_TXDATA) || (ofs == hsg_pkg::OFS_RXDATA) ||
                    (ofs == hsg_pkg::OFS_STATUS) || (ofs == hsg_pkg::OFS_CLEAR));
  assign wr_acc  = ce && psel && penable && pwrite && addr_ok;
  assign rd_acc  = ce && psel && penable && !pwrite && addr_ok;

  // Every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_q;

  // Read data is captured in the setup cycle so the bus sees a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (ofs)
        hsg_pkg::OFS_CTRL:   prdata_q <= ctrl_q[grp_sel];
        hsg_pkg::OFS_COUNT:  prdata_q <= count_q[grp_sel];
        hsg_pkg::OFS_RXDATA: prdata_q <= 32'(rx_q[grp_sel]);
        hsg_pkg::OFS_STATUS: prdata_q <= status_w[grp_sel];
        default:             prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign group1_data_out = dout_q[0];
  assign group2_data_out = dout_q[1];

  function automatic logic [2:0] width_bytes(input logic [1:0] code);
    case (code)
      hsg_pkg::WID_8:  width_bytes = 3'h1;
      hsg_pkg::WID_16: width_bytes = 3'h2;
      hsg_pkg::WID_32: width_bytes = 3'h4;
      default:         width_bytes = 3'h0;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] code);
    case (code)
      hsg_pkg::WID_8:  width_mask = DATA_W'(32'h0000_00ff);
      hsg_pkg::WID_16: width_mask = DATA_W'(32'h0000_ffff);
      default:         width_mask = {DATA_W{1'b1}};
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : grp
      logic [2:0]               run;
      logic                     dir;
      logic                     counted;
      hsg_pkg::hsg_proto_e      proto;
      logic [1:0]               wid;
      logic [3:0]               fifo_asg;
      logic                     pclk_drive;
      logic [7:0]               rate_div;
      logic                     sel_wr;
      logic                     start_req;
      logic                     start_bad;
      logic                     clr_all;
      logic                     ack_s1, ack_s2, ack_s3;
      logic                     pck_s1, pck_s2, pck_s3;
      logic [DATA_W-1:0]        din_s1;
      logic [7:0]               div_cnt_q;
      logic                     pck_gen_q;
      logic                     pck_rise;
      logic                     ack_rise;
      logic                     ready_side;
      logic                     xfer;
      logic [31:0]              remain_q;
      logic [3:0]               pulse_q;
      hsg_pkg::hsg_state_e      st_q;
      logic                     req_q;

      assign run        = ctrl_q[g][hsg_pkg::CTL_RUN_LSB +: 3];
      assign dir        = ctrl_q[g][hsg_pkg::CTL_DIR_BIT];
      assign counted    = ctrl_q[g][hsg_pkg::CTL_CNT_BIT];
      assign proto      = hsg_pkg::hsg_proto_e'(ctrl_q[g][hsg_pkg::CTL_PROTO_LSB +: 3]);
      assign wid        = ctrl_q[g][hsg_pkg::CTL_WID_LSB +: 2];
      assign fifo_asg   = ctrl_q[g][hsg_pkg::CTL_FIFO_LSB +: 4];
      assign pclk_drive = ctrl_q[g][hsg_pkg::CTL_PDRV_BIT];
      assign rate_div   = ctrl_q[g][hsg_pkg::CTL_DIV_LSB +: 8];
      assign sel_wr     = wr_acc && (grp_sel == 1'(g));
      assign clr_all    = sel_wr && (ofs == hsg_pkg::OFS_CLEAR) &&
                          (pwdata[7:0] == hsg_pkg::CLEAR_ALL);

      // A start with an impossible setup is refused and flagged.
      assign start_req = sel_wr && (ofs == hsg_pkg::OFS_CTRL) &&
                         (run == hsg_pkg::RUN_RESET) &&
                         (pwdata[hsg_pkg::CTL_RUN_LSB +: 3] == hsg_pkg::RUN_GO);
      assign start_bad = (width_bytes(pwdata[hsg_pkg::CTL_WID_LSB +: 2]) == 3'h0) ||
                         (width_bytes(pwdata[hsg_pkg::CTL_WID_LSB +: 2]) >
                          3'($countones(pwdata[hsg_pkg::CTL_FIFO_LSB +: 4]))) ||
                         (pwdata[hsg_pkg::CTL_CNT_BIT] && (count_q[g] == 32'h0));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q[g]  <= hsg_pkg::CTL_RESET;
          count_q[g] <= 32'h0000_0000;
        end else if (sel_wr) begin
          if (ofs == hsg_pkg::OFS_CTRL) begin
            if (run == hsg_pkg::RUN_RESET) begin
              // Setup fields only move while the group is held in reset.
              ctrl_q[g] <= start_req && start_bad ?
                           {pwdata[31:3], hsg_pkg::RUN_RESET} : pwdata;
            end else begin
              ctrl_q[g] <= {ctrl_q[g][31:3], pwdata[hsg_pkg::CTL_RUN_LSB +: 3]};
            end
          end
          if ((ofs == hsg_pkg::OFS_COUNT) && (run == hsg_pkg::RUN_RESET)) begin
            count_q[g] <= pwdata;
          end
        end
      end

      // Pins from the device pass two flops before any logic sees them.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ack_s1    <= 1'b0;
          ack_s2    <= 1'b0;
          ack_s3    <= 1'b0;
          pck_s1    <= 1'b0;
          pck_s2    <= 1'b0;
          pck_s3    <= 1'b0;
          din_s1    <= '0;
          din_s2[g] <= '0;
        end else if (ce) begin
          ack_s1    <= group_ack_in[g];
          ack_s2    <= ack_s1;
          ack_s3    <= ack_s2;
          pck_s1    <= group_periph_clock_in[g];
          pck_s2    <= pck_s1;
          pck_s3    <= pck_s2;
          din_s1    <= (g == 0) ? group1_data_in : group2_data_in;
          din_s2[g] <= din_s1;
        end
      end

      assign ack_rise = ack_s2 && !ack_s3;

      // Burst clock: our divider when we drive it, else edges of the device's clock.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          div_cnt_q <= 8'h00;
          pck_gen_q <= 1'b0;
        end else if (ce) begin
          if (st_q != hsg_pkg::HS_BURST || !pclk_drive) begin
            div_cnt_q <= 8'h00;
            pck_gen_q <= 1'b0;
          end else if (div_cnt_q >= rate_div) begin
            div_cnt_q <= 8'h00;
            pck_gen_q <= !pck_gen_q;
          end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
          end
        end
      end

      assign pck_rise = pclk_drive ?
                        (st_q == hsg_pkg::HS_BURST) && !pck_gen_q && (div_cnt_q >= rate_div) :
                        (pck_s2 && !pck_s3);
      assign group_periph_clock_out[g] = pck_gen_q;
      assign group_periph_clock_oe[g]  = (st_q == hsg_pkg::HS_BURST) && pclk_drive;

      // We are ready when we hold a word to send or have room for one.
      assign ready_side = (dir == hsg_pkg::DIR_IN) ? tx_full_q[g] : !rx_valid_q[g];
      assign xfer = (st_q == hsg_pkg::HS_REQ  && ack_rise) ||
                    (st_q == hsg_pkg::HS_BURST && pck_rise && req_q && ack_s2);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_q     <= hsg_pkg::HS_IDLE;
          req_q    <= 1'b0;
          pulse_q  <= 4'h0;
          remain_q <= 32'h0000_0000;
        end else if (ce) begin
          if (run != hsg_pkg::RUN_GO) begin
            st_q     <= hsg_pkg::HS_IDLE;
            req_q    <= 1'b0;
            remain_q <= count_q[g];
          end else begin
            case (st_q)
              hsg_pkg::HS_IDLE: begin
                if (counted && remain_q == 32'h0) begin
                  st_q <= hsg_pkg::HS_DONE;
                end else if (ready_side && !ack_s2) begin
                  req_q   <= 1'b1;
                  pulse_q <= (proto == hsg_pkg::HSG_LONG) ? 4'(hsg_pkg::LONG_CYC) :
                                                              4'(hsg_pkg::PULSE_CYC);
                  st_q    <= (proto == hsg_pkg::HSG_BURST) ? hsg_pkg::HS_BURST
                                                            : hsg_pkg::HS_REQ;
                end
              end
              hsg_pkg::HS_REQ: begin
                // Pulsed protocols drop the request after a fixed width.
                if (proto != hsg_pkg::HSG_LEVEL && pulse_q != 4'h0) begin
                  pulse_q <= pulse_q - 4'h1;
                end else if (proto != hsg_pkg::HSG_LEVEL) begin
                  req_q <= 1'b0;
                end
                if (xfer) begin
                  req_q <= 1'b0;
                  st_q  <= hsg_pkg::HS_HOLD;
                end
              end
              hsg_pkg::HS_HOLD: begin
                if (!ack_s2) begin
                  st_q <= hsg_pkg::HS_IDLE;
                end
              end
              hsg_pkg::HS_BURST: begin
                req_q <= ready_side && !xfer;
                if (counted && xfer && remain_q == 32'h1) begin
                  req_q <= 1'b0;
                  st_q  <= hsg_pkg::HS_DONE;
                end
              end
              hsg_pkg::HS_DONE: begin
                req_q <= 1'b0;
              end
              default: begin
                st_q  <= hsg_pkg::HS_IDLE;
                req_q <= 1'b0;
              end
            endcase
            if (xfer && counted) begin
              remain_q <= remain_q - 32'h1;
            end
          end
        end
      end

      assign group_req_out[g] = req_q;

      // Outgoing word stays on the lines until the device acknowledges it.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_q[g]       <= '0;
          tx_full_q[g]  <= 1'b0;
          dout_q[g]     <= '0;
          rx_q[g]       <= '0;
          rx_valid_q[g] <= 1'b0;
        end else if (ce) begin
          if (sel_wr && ofs == hsg_pkg::OFS_TXDATA && !tx_full_q[g] &&
              width_bytes(wid) != 3'h0) begin
            tx_q[g]      <= pwdata[DATA_W-1:0] & width_mask(wid);
            tx_full_q[g] <= 1'b1;
          end else if (xfer && dir == hsg_pkg::DIR_IN) begin
            tx_full_q[g] <= 1'b0;
          end
          if (st_q == hsg_pkg::HS_IDLE || (st_q == hsg_pkg::HS_BURST && pck_rise)) begin
            dout_q[g] <= tx_q[g];
          end
          if (xfer && dir == hsg_pkg::DIR_OUT) begin
            rx_q[g]       <= din_s2[g] & width_mask(wid);
            rx_valid_q[g] <= 1'b1;
          end else if (rd_acc && grp_sel == 1'(g) && ofs == hsg_pkg::OFS_RXDATA) begin
            rx_valid_q[g] <= 1'b0;
          end
        end
      end

      assign group_data_oe[g] = (run == hsg_pkg::RUN_GO) && (dir == hsg_pkg::DIR_IN) &&
                                tx_full_q[g];

      // Hardware setting a flag wins over a clear in the same cycle.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          done_q[g] <= 1'b0;
          err_q[g]  <= 1'b0;
        end else if (ce) begin
          if (counted && xfer && remain_q == 32'h1) begin
            done_q[g] <= 1'b1;
          end else if (clr_all) begin
            done_q[g] <= 1'b0;
          end
          if (start_req && start_bad) begin
            err_q[g] <= 1'b1;
          end else if (clr_all) begin
            err_q[g] <= 1'b0;
          end
        end
      end

      always_comb begin
        status_w[g]                        = 32'h0000_0000;
        status_w[g][hsg_pkg::ST_DONE_BIT]  = done_q[g];
        status_w[g][hsg_pkg::ST_RESID_BIT] = rx_valid_q[g] &&
                                             (run == hsg_pkg::RUN_RESET);
        status_w[g][hsg_pkg::ST_TXF_BIT]   = tx_full_q[g];
        status_w[g][hsg_pkg::ST_RXV_BIT]   = rx_valid_q[g];
        status_w[g][hsg_pkg::ST_BUSY_BIT]  = (run == hsg_pkg::RUN_GO) &&
                                             (st_q != hsg_pkg::HS_DONE);
        status_w[g][hsg_pkg::ST_ERR_BIT]   = err_q[g];
      end
    end
  endgenerate

endmodule

// File: logic/hsg_pkg.sv
// Constants for the two-group handshake peripheral controller.
// Assumes a 25 MHz pclk and software reaching the registers over APB.
package hsg_pkg;

  localparam int          NUM_GROUPS    = 2;
  localparam int          DATA_W        = 32;

  // Register offsets within one group window, and the window stride.
  localparam logic [7:0]  GRP_STRIDE    = 8'h20;
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_COUNT     = 5'h04;
  localparam logic [4:0]  OFS_TXDATA    = 5'h08;
  localparam logic [4:0]  OFS_RXDATA    = 5'h0c;
  localparam logic [4:0]  OFS_STATUS    = 5'h10;
  localparam logic [4:0]  OFS_CLEAR     = 5'h14;

  // Control register fields.
  localparam int          CTL_RUN_LSB   = 0;
  localparam int          CTL_DIR_BIT   = 3;
  localparam int          CTL_CNT_BIT   = 4;
  localparam int          CTL_PROTO_LSB = 5;
  localparam int          CTL_WID_LSB   = 8;
  localparam int          CTL_FIFO_LSB  = 10;
  localparam int          CTL_PDRV_BIT  = 14;
  localparam int          CTL_DIV_LSB   = 16;
  localparam logic [31:0] CTL_RESET     = 32'h0000_0000;

  // Status register bits.
  localparam int          ST_DONE_BIT   = 0;
  localparam int          ST_RESID_BIT  = 1;
  localparam int          ST_TXF_BIT    = 2;
  localparam int          ST_RXV_BIT    = 3;
  localparam int          ST_BUSY_BIT   = 4;
  localparam int          ST_ERR_BIT    = 5;

  // Run control field codes.
  localparam logic [2:0]  RUN_RESET     = 3'h0;
  localparam logic [2:0]  RUN_GO        = 3'h7;

  // Direction as seen by the device: 0 device input, 1 device output.
  localparam logic        DIR_IN        = 1'b0;
  localparam logic        DIR_OUT       = 1'b1;

  // Funneling codes of the device.
  localparam logic [1:0]  FUNNEL_DIRECT = 2'h0;
  localparam logic [1:0]  FUNNEL_8_16   = 2'h2;

  // Access width codes.
  localparam logic [1:0]  WID_32        = 2'h0;
  localparam logic [1:0]  WID_8         = 2'h2;
  localparam logic [1:0]  WID_16        = 2'h3;

  localparam logic [7:0]  CLEAR_ALL     = 8'hff;

  typedef enum logic [2:0] {
    HSG_EMUL  = 3'h0,
    HSG_LEVEL = 3'h1,
    HSG_LEAD  = 3'h2,
    HSG_LONG  = 3'h3,
    HSG_TRAIL = 3'h4,
    HSG_BURST = 3'h5
  } hsg_proto_e;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'b00001,
    HS_REQ   = 5'b00010,
    HS_HOLD  = 5'b00100,
    HS_BURST = 5'b01000,
    HS_DONE  = 5'b10000
  } hsg_state_e;

  // Request pulse widths for the pulsed protocols.
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          PULSE_NS      = 200;
  localparam int          LONG_PULSE_NS = 400;
  localparam int          PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LONG_CYC      = (LONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: verification/hsg_dev_model.sv
// Behavioural device side of both handshake groups with level-style acknowledges.
// Assumes requests arrive on pclk edges; the ack delay is counted in pclk cycles.
`timescale 1ns/100ps
module hsg_dev_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  dly,
  input  wire logic [1:0]  req,
  input  wire logic [1:0]  hoe,
  input  wire logic [31:0] hd [2],
  output logic      [1:0]  ack,
  output logic      [31:0] dd [2],
  output logic      [31:0] cap [2],
  output logic      [7:0]  n [2]
);
  for (genvar g = 0; g < 2; g++) begin : grp
    logic        pnd_q;
    logic        ack_q;
    logic [3:0]  c_q;
    logic [7:0]  n_q;
    logic [31:0] cap_q;
    assign ack[g] = ack_q;
    assign n[g]   = n_q;
    assign cap[g] = cap_q;
    // Released lines show the inverse word, so a late sample can never match.
    assign dd[g]  = (pnd_q || ack_q) ? 32'h1234_5678 + n_q :
                    ~(32'h1234_5678 + n_q - 32'h1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pnd_q <= 1'b0;
        ack_q <= 1'b0;
        c_q   <= 4'h0;
        n_q   <= 8'h00;
        cap_q <= 32'h0;
      end else if (!ack_q) begin
        if (req[g]) pnd_q <= 1'b1;
        if (pnd_q) c_q <= c_q + 4'h1;
        if (pnd_q && c_q >= dly) begin
          ack_q <= 1'b1;
          pnd_q <= 1'b0;
          c_q   <= 4'h0;
          if (hoe[g]) cap_q <= hd[g];
        end
      end else if (!req[g]) begin
        ack_q <= 1'b0;
        n_q   <= n_q + 8'h01;
      end
    end
  end
endmodule

// File: verification/hsg_host_monitor.sv
// Concurrent checks on the host controller ports, bound into every hsg_host.
// Assumes software changes a group setup only while its run field is reset.
`timescale 1ns/100ps
module hsg_host_monitor #(
  parameter int DATA_W = hsg_pkg::DATA_W
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [1:0]        group_req_out,
  input wire logic [1:0]        group_ack_in,
  input wire logic [1:0]        group_periph_clock_oe,
  input wire logic [DATA_W-1:0] group1_data_out,
  input wire logic [1:0]        group_data_oe
);
  logic [2:0] run_q [2];
  logic [2:0] prt_q [2];
  logic [2:0] idl_q [2];
  logic [1:0] dir_q;
  logic [1:0] drv_q;
  logic       wr;
  logic       mapped;
  assign wr = psel && penable && pwrite && ce && paddr[4:0] == hsg_pkg::OFS_CTRL
              && paddr[7:6] == 2'h0;
  assign mapped = paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0 && paddr[4:0] <= hsg_pkg::OFS_CLEAR;
  // Shadow of each group's control word, so checks can depend on protocol and direction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '{3'h0, 3'h0};
      prt_q <= '{3'h0, 3'h0};
      idl_q <= '{3'h7, 3'h7};
      dir_q <= 2'h0;
      drv_q <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        idl_q[g] <= {idl_q[g][1:0], run_q[g] == hsg_pkg::RUN_RESET};
        if (wr && paddr[5] == g[0]) begin
          run_q[g] <= pwdata[2:0];
          if (pwdata[2:0] == hsg_pkg::RUN_RESET) begin
            prt_q[g] <= pwdata[7:5];
            dir_q[g] <= pwdata[3];
            drv_q[g] <= pwdata[14];
          end
        end
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr; psel && penable |-> pslverr == !mapped; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_req_rise; $rose(group_req_out[0]) |-> !group_ack_in[0] && !$past(group_ack_in[0]);
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("req rose with ack");
  property p_tx_stable;
    group_req_out[0] && group_data_oe[0] && $past(group_req_out[0] && group_data_oe[0])
    |-> $stable(group1_data_out);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("data moved in request");
  property p_req_drop;
    prt_q[0] == hsg_pkg::HSG_LEVEL && group_req_out[0] && group_ack_in[0]
    |-> ##[1:4] !group_req_out[0];
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("req held after ack");
  property p_oe_dir; group_data_oe[0] |-> dir_q[0] == hsg_pkg::DIR_IN; endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("data driven wrong way");
  property p_idle; &idl_q[1] && run_q[1] == 3'h0 |-> group_req_out[1] == 1'b0; endproperty
  a_idle: assert property (p_idle) else $error("request in reset");
  property p_clk_oe;
    group_periph_clock_oe[0] |-> prt_q[0] == hsg_pkg::HSG_BURST && drv_q[0];
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock driven off burst");
  c_group1_ack_out: cover property (group_req_out[0] && group_ack_in[0]);
  c_group2_ack_out: cover property (group_req_out[1] && group_ack_in[1]);
  c_err: cover property (pslverr);
endmodule
bind hsg_host hsg_host_monitor #(.DATA_W(DATA_W)) mon_u (.pclk, .presetn, .ce, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pready, .pslverr, .group_req_out, .group_ack_in,
  .group_periph_clock_oe, .group1_data_out, .group_data_oe);

// File: verification/hsg_host_tb_top.sv
// Self-checking bench: APB tasks drive the host, a device model answers both groups.
// Assumes the design answers APB with no wait states but never relies on it.
`timescale 1ns/100ps
module hsg_host_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  dly = 4'h1;
  logic        ce = 1'b1;
  logic [1:0]  pci = 2'h0;
  logic [31:0] prdata, r, c, c2;
  logic        pready, pslverr, e;
  logic [1:0]  req, ack, doe, pco, pck;
  logic [31:0] hd [2];
  logic [31:0] dd [2];
  logic [31:0] cap [2];
  logic [7:0]  n [2];
  int          n_errors = 0;
  int          compares = 0;

  always #20 pclk = ~pclk;
  always #160 pci = ~pci & req;

  hsg_host dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group_req_out(req), .group_ack_in(ack), .group_periph_clock_in(pci),
    .group_periph_clock_out(pck), .group_periph_clock_oe(pco), .group1_data_in(dd[0]),
    .group2_data_in(dd[1]), .group1_data_out(hd[0]), .group2_data_out(hd[1]),
    .group_data_oe(doe));
  hsg_dev_model dev_u (.pclk(pclk), .presetn(presetn), .dly(dly), .req(req), .hoe(doe),
    .hd(hd), .ack(ack), .dd(dd), .cap(cap), .n(n));

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ctl(logic dir, logic cnt, logic [2:0] p, logic [1:0] w,
                                      logic [3:0] f, logic drv);
    return {17'h0, drv, f, w, p, cnt, dir, hsg_pkg::RUN_RESET};
  endfunction
  task automatic run(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
    bus(1'b1, a, v | {29'h0, hsg_pkg::RUN_GO});
  endtask
  task automatic wait_n(input int g, input logic [7:0] t);
    for (int i = 0; i < 400 && n[g] !== t; i++) @(posedge pclk);
    chk(n[g], t);
  endtask
  task automatic wait_st(input logic [7:0] a, input int b);
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, a, 32'h0);
      if (r[b] === 1'b1) break;
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_errors++;
    stop_test;
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk(r, hsg_pkg::CTL_RESET);
    bus(1'b0, 8'h18, 32'h0);
    chk(e, 1'b1);
    // A 32-bit width on a single byte FIFO must be refused.
    run(8'h00, ctl(hsg_pkg::DIR_IN, 1'b0, hsg_pkg::HSG_LEVEL, hsg_pkg::WID_32, 4'h1, 1'b0));
    bus(1'b0, 8'h00, 32'h0);
    chk(r[2:0], hsg_pkg::RUN_RESET);
    bus(1'b0, 8'h10, 32'h0);
    chk(r[hsg_pkg::ST_ERR_BIT], 1'b1);
    bus(1'b1, 8'h14, {24'h0, hsg_pkg::CLEAR_ALL});
    bus(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    // Both groups run at once, one sending and one receiving.
    c = ctl(hsg_pkg::DIR_IN, 1'b1, hsg_pkg::HSG_LEVEL, hsg_pkg::WID_8, 4'h1, 1'b0);
    c2 = ctl(hsg_pkg::DIR_OUT, 1'b0, hsg_pkg::HSG_LEVEL, hsg_pkg::WID_16, 4'hc, 1'b0);
    bus(1'b1, 8'h00, c);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h08, 32'hffff_ffa5);
    run(8'h20, c2);
    run(8'h00, c);
    wait_n(0, 8'h01);
    chk(cap[0], 32'h0000_00a5);
    wait_st(8'h30, hsg_pkg::ST_RXV_BIT);
    bus(1'b0, 8'h2c, 32'h0);
    chk(r, 32'h0000_5678);
    dly <= 4'h6;
    bus(1'b1, 8'h08, 32'h0000_013c);
    wait_n(0, 8'h02);
    chk(cap[0], 32'h0000_003c);
    wait_st(8'h10, hsg_pkg::ST_DONE_BIT);
    chk(r[hsg_pkg::ST_DONE_BIT], 1'b1);
    bus(1'b1, 8'h00, c);
    bus(1'b1, 8'h14, {24'h0, hsg_pkg::CLEAR_ALL});
    bus(1'b0, 8'h10, 32'h0);
    chk(r[hsg_pkg::ST_DONE_BIT], 1'b0);
    ce <= 1'b0;
    bus(1'b1, 8'h04, 32'h9);
    ce <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(r, 32'h2);
    wait_st(8'h30, hsg_pkg::ST_RXV_BIT);
    bus(1'b1, 8'h20, c2);
    bus(1'b0, 8'h30, 32'h0);
    chk(r[hsg_pkg::ST_RESID_BIT], 1'b1);
    bus(1'b0, 8'h2c, 32'h0);
    chk(r, 32'h0000_5679);
    bus(1'b0, 8'h30, 32'h0);
    chk(r[hsg_pkg::ST_RESID_BIT], 1'b0);
    dly <= 4'h1;
    for (int p = 0; p < 5; p++) begin
      c = ctl(hsg_pkg::DIR_IN, 1'b0, p[2:0], hsg_pkg::WID_8, 4'h1, 1'b0);
      bus(1'b1, 8'h00, c);
      bus(1'b1, 8'h08, 32'h40 + p);
      run(8'h00, c);
      wait_n(0, n[0] + 8'h01);
      chk(cap[0], 32'h40 + p);
      bus(1'b1, 8'h00, c);
    end
    c = ctl(hsg_pkg::DIR_IN, 1'b0, hsg_pkg::HSG_BURST, hsg_pkg::WID_8, 4'h1, 1'b1);
    bus(1'b1, 8'h00, c);
    bus(1'b1, 8'h08, 32'h55);
    run(8'h00, c);
    for (int i = 0; i < 50 && pco[0] !== 1'b1; i++) @(posedge pclk);
    chk(pco[0], 1'b1);
    e = pck[0];
    @(posedge pclk);
    chk(pck[0], !e);
    wait_n(0, 8'h08);
    chk(cap[0], 32'h55);
    bus(1'b1, 8'h00, c);
    run(8'h20, c2 | 32'h80);
    wait_st(8'h30, hsg_pkg::ST_RXV_BIT);
    bus(1'b0, 8'h2c, 32'h0);
    chk(r, 32'h0000_567a);
    stop_test;
  end
endmodule
